// ==== design/xray_accept_pkg.sv ====
// Purpose: shared constants of the x-ray event acceptance analyzer
// Assumes: core clock 25 MHz; all times given in nanoseconds
// Notes:   cycle counts derive from the times; least times round up
package xray_accept_pkg;

  // ------------------------------------------------------------------
  // clock and times
  // ------------------------------------------------------------------
  localparam int unsigned CLK_NS        = 40;
  localparam int unsigned DELAY_NS      = 2000;      // front-end hold-back
  localparam int unsigned GATE_NS       = 5000;      // linear gate width
  localparam int unsigned SEL_DELAY_NS  = 5000;      // select-bit delay
  localparam int unsigned STOP_NS       = 10000;     // stop gate pulse
  localparam int unsigned PAIR_NS       = 5000;      // krypton/cesium pairing
  localparam int unsigned OSC_NS        = 2000;      // gated oscillator period
  localparam int unsigned BUSY_NS       = 13000000;  // dead time after event
  localparam int unsigned RISE_MIN_NS   = 500;
  localparam int unsigned RISE_MAX_NS   = 1800;

  localparam int unsigned DELAY_CYC     = (DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GATE_CYC      = (GATE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SEL_DELAY_CYC = (SEL_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STOP_CYC      = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PAIR_CYC      = (PAIR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OSC_CYC       = (OSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BUSY_CYC      = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RISE_MIN_CYC  = (RISE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RISE_MAX_CYC  = RISE_MAX_NS / CLK_NS;

  // ------------------------------------------------------------------
  // widths and defaults
  // ------------------------------------------------------------------
  localparam int unsigned SCALER_W   = 6;
  localparam int unsigned PRESCALE_W = 2;
  localparam int unsigned RISE_W     = 7;
  localparam int unsigned OSC_W      = 6;
  localparam int unsigned NTRK       = 16;

  // ------------------------------------------------------------------
  // synchronised input vector, bit positions
  // ------------------------------------------------------------------
  localparam int unsigned IN_KR_LOW   = 0;
  localparam int unsigned IN_KR_HIGH  = 1;
  localparam int unsigned IN_CS_LOW   = 2;
  localparam int unsigned IN_CS_HIGH  = 3;
  localparam int unsigned IN_SHAPER   = 4;
  localparam int unsigned IN_PEAK     = 5;
  localparam int unsigned IN_PL10     = 6;
  localparam int unsigned IN_PL20     = 7;
  localparam int unsigned IN_PL40     = 8;
  localparam int unsigned IN_PL100    = 9;
  localparam int unsigned IN_CONV     = 10;
  localparam int unsigned IN_MAIN_INH = 11;
  localparam int unsigned IN_RDOUT    = 12;
  localparam int unsigned IN_RATE_SEQ = 13;
  localparam int unsigned IN_OVL_WIN  = 14;
  localparam int unsigned IN_OVL_SEQ  = 15;
  localparam int unsigned IN_SCL_RST  = 16;
  localparam int unsigned NIN         = 17;

  // ------------------------------------------------------------------
  // tape track bit positions (bit n-1 carries track n)
  // ------------------------------------------------------------------
  localparam int unsigned TRK_KR_SEL = 13;   // track 14
  localparam int unsigned TRK_MODE   = 14;   // track 15
  localparam int unsigned TRK_CS_SEL = 15;   // track 16
  localparam int unsigned TRK_R0     = 6;    // track 7
  localparam int unsigned TRK_R1     = 7;    // track 8
  localparam int unsigned TRK_R2     = 9;    // track 10
  localparam int unsigned TRK_R3     = 10;   // track 11
  localparam int unsigned TRK_R4     = 11;   // track 12
  localparam int unsigned TRK_R5     = 12;   // track 13

endpackage

// ==== design/one_shot.sv ====
// Purpose: retriggerable one-shot timer with end-of-pulse strobe
// Assumes: trig is a one-cycle strobe on core_clk
// Notes:   active stays high WIDTH_CYC cycles after the last trigger
`timescale 1ns/1ps
`default_nettype none

module one_shot #(
  parameter int unsigned WIDTH_CYC = 1,
  parameter int unsigned CW        = $clog2(WIDTH_CYC + 1)
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // control
  input  wire logic trig,
  // status
  output logic      active,
  output logic      done
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          act;
    logic          done;
  } shot_s;

  shot_s q;
  shot_s d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (trig) begin
      d.cnt = CW'(WIDTH_CYC - 1);
      d.act = 1'b1;
    end else if (q.act) begin
      if (q.cnt == '0) begin
        d.act  = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign active = q.act;
  assign done   = q.done;

endmodule // one_shot

`default_nettype wire

// ==== design/xray_event_acceptance_analyzer.sv ====
// Purpose: event acceptance, pulse-height counting and tape readout
// Assumes: discriminator and timing inputs are asynchronous levels
// Notes:   analog shaping and mode sequencing live outside this block
//
// Overview of operation
// - good krypton event analyzed only when idle
// - decision waits two microseconds before the gate
// - accepted event opens linear gate five microseconds
// - oscillator pulses counted in six-bit binary
// - readout command moves count to tracks 1-6
// - delayed low threshold sets krypton select bit
// - krypton rate counted ahead of main inhibit
// - rate counting stops during rate readout
// - high krypton threshold fires the stop gate
// - cesium good between 20 and 100 kev
// - cesium select bit set like krypton's
// - cesium rate accumulator read every five seconds
// - cesium overload counted only in window
// - overload readout marks tracks 14 and 15
// - coincidence of shaper and peak marks plastic
// - coincidence stops gates and cesium overload accumulation
// - rise time decides which channels analyze
// - four plastic thresholds classify pulse height
// - plastic overload counted in window, rate tracks
// - stop gate fires on four listed causes
// - events during thirteen millisecond dead time rejected
`timescale 1ns/1ps
`default_nettype none

module xray_event_acceptance_analyzer #(
  parameter int unsigned SCALER_W   = xray_accept_pkg::SCALER_W,
  parameter int unsigned PRESCALE_W = xray_accept_pkg::PRESCALE_W,
  parameter int unsigned BUSY_CYC   = xray_accept_pkg::BUSY_CYC
) (
  // clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             sys_rst,
  // krypton and cesium discriminators
  input  wire logic                             krLowThr,
  input  wire logic                             krHighThr,
  input  wire logic                             csLowThr,
  input  wire logic                             csHighThr,
  // plastic origin discrimination and thresholds
  input  wire logic                             fastShaper,
  input  wire logic                             peakDetect,
  input  wire logic                             plThr10,
  input  wire logic                             plThr20,
  input  wire logic                             plThr40,
  input  wire logic                             plThr100,
  // conversion drive from pulse shaper
  input  wire logic                             convDrive,
  // timing generator and mode sequencing
  input  wire logic                             mainInhibit,
  input  wire logic                             readoutCmd,
  input  wire logic                             rateReadout,
  input  wire logic                             overloadWindow,
  input  wire logic                             overloadReadout,
  input  wire logic                             scalerReset,
  // tape heads
  output logic      [xray_accept_pkg::NTRK-1:0] tapeTracks,
  output logic                                  tapeWrite,
  // analyzer status
  output logic                                  linGateOpen,
  output logic                                  stopGateOut,
  output logic                                  analyzerBusy,
  output logic      [1:0]                       plChannel,
  output logic                                  plValid
);

  localparam int unsigned NIN = xray_accept_pkg::NIN;
  localparam int unsigned NT  = xray_accept_pkg::NTRK;
  localparam int unsigned RW  = xray_accept_pkg::RISE_W;
  localparam int unsigned OW  = xray_accept_pkg::OSC_W;

  typedef struct packed {
    logic [NIN-1:0]        s1;
    logic [NIN-1:0]        s2;
    logic [NIN-1:0]        s3;
    logic [RW-1:0]         riseCnt;
    logic                  shaperSeen;
    logic [OW-1:0]         oscCnt;
    logic                  convActive;
    logic [SCALER_W-1:0]   phCount;
    logic [SCALER_W-1:0]   krRate;
    logic [SCALER_W-1:0]   csRate;
    logic [SCALER_W-1:0]   csOvl;
    logic [SCALER_W-1:0]   plOvl;
    logic [PRESCALE_W-1:0] krPre;
    logic                  krSel;
    logic                  csSel;
    logic [1:0]            plChan;
    logic                  plValid;
    logic [NT-1:0]         tracks;
    logic                  tapeWr;
  } state_s;

  state_s q;
  state_s d;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // six-bit value onto the rate-accumulator tracks
  function automatic logic [NT-1:0] rateTracks(input logic [SCALER_W-1:0] v);
    logic [NT-1:0] t;
    t = '0;
    t[xray_accept_pkg::TRK_R0] = v[0];
    t[xray_accept_pkg::TRK_R1] = v[1];
    t[xray_accept_pkg::TRK_R2] = v[2];
    t[xray_accept_pkg::TRK_R3] = v[3];
    t[xray_accept_pkg::TRK_R4] = v[4];
    t[xray_accept_pkg::TRK_R5] = v[5];
    return t;
  endfunction

  // scaler onto tracks 1-6
  function automatic logic [NT-1:0] lowTracks(input logic [SCALER_W-1:0] v);
    return NT'(v);
  endfunction

  // ------------------------------------------------------------------
  // pin levels and strobes
  // ------------------------------------------------------------------
  logic [NIN-1:0] pins;
  logic [NIN-1:0] lvl;
  logic [NIN-1:0] stb;

  assign pins = {scalerReset, overloadReadout, overloadWindow, rateReadout,
                 readoutCmd, mainInhibit, convDrive, plThr100, plThr40,
                 plThr20, plThr10, peakDetect, fastShaper, csHighThr,
                 csLowThr, krHighThr, krLowThr};
  assign lvl  = q.s2;
  assign stb  = q.s2 & ~q.s3;

  // ------------------------------------------------------------------
  // timers
  // ------------------------------------------------------------------
  logic dlyADone;
  logic dlyBDone;
  logic selADone;
  logic selBDone;
  logic gateAct;
  logic stopAct;
  logic plIndAct;
  logic pairAAct;
  logic pairBAct;
  logic busyAct;
  logic coinc;
  logic pairHit;
  logic acceptA;
  logic acceptB;
  logic stopTrig;

  // fast rise means plastic or a too-fast cesium pulse
  assign coinc = stb[xray_accept_pkg::IN_PEAK] &&
                 (stb[xray_accept_pkg::IN_SHAPER] ||
                  (q.shaperSeen &&
                   q.riseCnt < RW'(xray_accept_pkg::RISE_MIN_CYC)));

  assign pairHit = (stb[xray_accept_pkg::IN_KR_LOW] && pairBAct) ||
                   (stb[xray_accept_pkg::IN_CS_LOW] && pairAAct) ||
                   (stb[xray_accept_pkg::IN_KR_LOW] &&
                    stb[xray_accept_pkg::IN_CS_LOW]);

  assign stopTrig = stb[xray_accept_pkg::IN_KR_HIGH] ||
                    stb[xray_accept_pkg::IN_CS_HIGH] ||
                    coinc || pairHit;

  // dead time and main inhibit both hold off a new conversion
  assign acceptA = dlyADone && !stopAct && !lvl[xray_accept_pkg::IN_MAIN_INH] &&
                   !busyAct && !gateAct;
  assign acceptB = dlyBDone && !stopAct && !lvl[xray_accept_pkg::IN_MAIN_INH] &&
                   !busyAct && !gateAct;

  one_shot #(.WIDTH_CYC(xray_accept_pkg::DELAY_CYC)) u_dlyA (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stb[xray_accept_pkg::IN_KR_LOW]), .active(), .done(dlyADone));
  one_shot #(.WIDTH_CYC(xray_accept_pkg::DELAY_CYC)) u_dlyB (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stb[xray_accept_pkg::IN_CS_LOW]), .active(), .done(dlyBDone));
  one_shot #(.WIDTH_CYC(xray_accept_pkg::SEL_DELAY_CYC)) u_selA (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stb[xray_accept_pkg::IN_KR_LOW]), .active(), .done(selADone));
  one_shot #(.WIDTH_CYC(xray_accept_pkg::SEL_DELAY_CYC)) u_selB (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stb[xray_accept_pkg::IN_CS_LOW]), .active(), .done(selBDone));
  one_shot #(.WIDTH_CYC(xray_accept_pkg::GATE_CYC)) u_gate (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(acceptA || acceptB), .active(gateAct), .done());
  one_shot #(.WIDTH_CYC(xray_accept_pkg::STOP_CYC)) u_stop (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stopTrig), .active(stopAct), .done());
  one_shot #(.WIDTH_CYC(xray_accept_pkg::STOP_CYC)) u_plInd (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(coinc), .active(plIndAct), .done());
  one_shot #(.WIDTH_CYC(xray_accept_pkg::PAIR_CYC)) u_pairA (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stb[xray_accept_pkg::IN_KR_LOW]), .active(pairAAct), .done());
  one_shot #(.WIDTH_CYC(xray_accept_pkg::PAIR_CYC)) u_pairB (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(stb[xray_accept_pkg::IN_CS_LOW]), .active(pairBAct), .done());
  one_shot #(.WIDTH_CYC(BUSY_CYC)) u_busy (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .trig(acceptA || acceptB), .active(busyAct), .done());

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d        = q;
    d.s1     = pins;
    d.s2     = q.s1;
    d.s3     = q.s2;
    d.tapeWr = 1'b0;

    // rise time from shaper to peak
    if (stb[xray_accept_pkg::IN_SHAPER]) begin
      d.riseCnt    = '0;
      d.shaperSeen = 1'b1;
    end else if (q.shaperSeen && q.riseCnt != '1) begin
      d.riseCnt = q.riseCnt + RW'(1);
    end

    // four-channel class, withheld for fast or overly slow pulses
    if (stb[xray_accept_pkg::IN_PEAK]) begin
      d.shaperSeen = 1'b0;
      if (lvl[xray_accept_pkg::IN_PL100]) begin
        d.plChan = 2'h3;
      end else if (lvl[xray_accept_pkg::IN_PL40]) begin
        d.plChan = 2'h2;
      end else if (lvl[xray_accept_pkg::IN_PL20]) begin
        d.plChan = 2'h1;
      end else begin
        d.plChan = 2'h0;
      end
      d.plValid = lvl[xray_accept_pkg::IN_PL10] && !coinc && !stopAct &&
                  (stb[xray_accept_pkg::IN_SHAPER] ||
                   q.riseCnt <= RW'(xray_accept_pkg::RISE_MAX_CYC));
    end
    if (stopAct) begin
      d.plValid = 1'b0;
    end

    // scaler reset after parallel readout clears what was read
    if (stb[xray_accept_pkg::IN_SCL_RST]) begin
      d.phCount    = '0;
      d.krSel      = 1'b0;
      d.csSel      = 1'b0;
      d.convActive = 1'b0;
      d.oscCnt     = '0;
      if (lvl[xray_accept_pkg::IN_RATE_SEQ]) begin
        d.krRate = '0;
        d.csRate = '0;
      end
      if (lvl[xray_accept_pkg::IN_OVL_SEQ]) begin
        d.csOvl = '0;
        d.plOvl = '0;
      end
    end

    // gated oscillator drives the pulse-height binary
    if (acceptA || acceptB) begin
      d.convActive = 1'b1;
      d.oscCnt     = '0;
    end else if (q.convActive && lvl[xray_accept_pkg::IN_CONV]) begin
      if (q.oscCnt == OW'(xray_accept_pkg::OSC_CYC - 1)) begin
        d.oscCnt  = '0;
        d.phCount = q.phCount + SCALER_W'(1);
      end else begin
        d.oscCnt = q.oscCnt + OW'(1);
      end
    end

    // select bits, blocked by stop gate and main inhibit
    if (selADone && !stopAct && !lvl[xray_accept_pkg::IN_MAIN_INH]) begin
      d.krSel = 1'b1;
    end
    if (selBDone && !stopAct && !lvl[xray_accept_pkg::IN_MAIN_INH]) begin
      d.csSel = 1'b1;
    end

    // rate counting taken ahead of the main inhibit
    if (selADone && !stopAct && !lvl[xray_accept_pkg::IN_RATE_SEQ]) begin
      d.krPre = q.krPre + PRESCALE_W'(1);
      if (q.krPre == '1) begin
        d.krRate = q.krRate + SCALER_W'(1);
      end
    end
    if (selBDone && !stopAct && !lvl[xray_accept_pkg::IN_RATE_SEQ]) begin
      d.csRate = q.csRate + SCALER_W'(1);
    end

    // high-energy counting only inside the overload window
    if (stb[xray_accept_pkg::IN_CS_HIGH] && lvl[xray_accept_pkg::IN_OVL_WIN] &&
        !plIndAct && !coinc) begin
      d.csOvl = q.csOvl + SCALER_W'(1);
    end
    if (stb[xray_accept_pkg::IN_PL100] && lvl[xray_accept_pkg::IN_OVL_WIN]) begin
      d.plOvl = q.plOvl + SCALER_W'(1);
    end

    // parallel readout onto the tape heads
    if (stb[xray_accept_pkg::IN_RDOUT]) begin
      d.tapeWr = 1'b1;
      if (lvl[xray_accept_pkg::IN_OVL_SEQ]) begin
        d.tracks = lowTracks(q.csOvl) | rateTracks(q.plOvl);
        d.tracks[xray_accept_pkg::TRK_KR_SEL] = 1'b1;
        d.tracks[xray_accept_pkg::TRK_MODE]   = 1'b1;
      end else if (lvl[xray_accept_pkg::IN_RATE_SEQ]) begin
        d.tracks = lowTracks(q.csRate) | rateTracks(q.krRate);
        d.tracks[xray_accept_pkg::TRK_MODE] = 1'b1;
      end else begin
        d.tracks = lowTracks(q.phCount);
        d.tracks[xray_accept_pkg::TRK_KR_SEL] = q.krSel;
        d.tracks[xray_accept_pkg::TRK_CS_SEL] = q.csSel;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign tapeTracks   = q.tracks;
  assign tapeWrite    = q.tapeWr;
  assign linGateOpen  = gateAct;
  assign stopGateOut  = stopAct;
  assign analyzerBusy = busyAct;
  assign plChannel    = q.plChan;
  assign plValid      = q.plValid;

endmodule // xray_event_acceptance_analyzer

`default_nettype wire

// ==== test/timing_gen_model.sv ====
// Purpose: timing generator stand-in: inhibit, readout command, scaler reset
// Assumes: start is a one-cycle request from the bench
// Notes:   times scaled down; inhibit outlasts the readout like the real unit
`timescale 1ns/1ps
`default_nettype none
module timing_gen_model #(
  parameter int unsigned INH = 400,
  parameter int unsigned RD  = 300
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      mainInhibit,
  output logic      readoutCmd,
  output logic      scalerReset
);
  int unsigned cnt;
  always_ff @(posedge core_clk) begin
    if (sys_rst) cnt <= 0;
    else if (start) cnt <= 1;
    else if (cnt == 999) cnt <= 0;
    else if (cnt != 0) cnt <= cnt + 1;
  end
  assign mainInhibit = cnt != 0 && cnt <= INH;
  assign readoutCmd  = cnt >= RD && cnt < RD + 10;
  assign scalerReset = cnt >= RD + 20 && cnt < RD + 25;
endmodule // timing_gen_model
`default_nettype wire

// ==== test/xray_event_acceptance_analyzer_assertions.sv ====
// Purpose: port-level checks of the acceptance analyzer
// Assumes: single clock domain, synchronous reset
// Notes:   gap counter keeps the dead-time check cheap
`timescale 1ns/1ps
`default_nettype none
module xray_event_acceptance_analyzer_checker #(
  parameter int unsigned BUSY_CYC = xray_accept_pkg::BUSY_CYC
) (
  input wire logic                             core_clk,
  input wire logic                             sys_rst,
  input wire logic                             krHighThr,
  input wire logic                             readoutCmd,
  input wire logic [xray_accept_pkg::NTRK-1:0] tapeTracks,
  input wire logic                             tapeWrite,
  input wire logic                             linGateOpen,
  input wire logic                             stopGateOut,
  input wire logic                             analyzerBusy,
  input wire logic                             plValid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [19:0] gapQ;
  logic        seenQ;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gapQ  <= '0;
      seenQ <= 1'b0;
    end else if ($rose(linGateOpen)) begin
      gapQ  <= 20'h00001;
      seenQ <= 1'b1;
    end else if (gapQ != '1) begin
      gapQ <= gapQ + 20'h00001;
    end
  end
  AST_GATE_LEN: assert property ($rose(linGateOpen) |-> ##124 linGateOpen ##1 !linGateOpen)
    else $error("linear gate width wrong");
  AST_STOP_LEN: assert property ($rose(stopGateOut) |-> ##249 stopGateOut)
    else $error("stop gate pulse too short");
  AST_STOP_CAUSE: assert property ($rose(krHighThr) |-> ##[3:5] stopGateOut)
    else $error("stop gate missed high threshold");
  AST_GATE_BLOCK: assert property ($rose(linGateOpen) |-> !$past(stopGateOut))
    else $error("gate opened under stop gate");
  AST_BUSY_START: assert property ($rose(linGateOpen) |-> $rose(analyzerBusy))
    else $error("busy not raised with gate");
  AST_DEAD_TIME: assert property ($rose(linGateOpen) && seenQ |-> gapQ >= BUSY_CYC)
    else $error("event accepted in dead time");
  AST_WRITE_PULSE: assert property (tapeWrite |=> !tapeWrite)
    else $error("tape write longer than one cycle");
  AST_TRACKS_HOLD: assert property ($changed(tapeTracks) |-> tapeWrite)
    else $error("tracks changed without write");
  AST_READ_LAT: assert property ($rose(readoutCmd) |-> ##[3:5] tapeWrite)
    else $error("readout not answered");
  AST_PL_STOP: assert property (stopGateOut && $past(stopGateOut) |-> !plValid)
    else $error("plastic class valid under stop gate");
  cover property ($rose(linGateOpen));
  cover property ($rose(plValid));
  cover property (tapeWrite && tapeTracks[14]);
endmodule // xray_event_acceptance_analyzer_checker
bind xray_event_acceptance_analyzer xray_event_acceptance_analyzer_checker #(
  .BUSY_CYC(BUSY_CYC)
) i_chk (.core_clk, .sys_rst, .krHighThr, .readoutCmd, .tapeTracks, .tapeWrite,
  .linGateOpen, .stopGateOut, .analyzerBusy, .plValid);
`default_nettype wire

// ==== test/xray_event_acceptance_analyzer_test.sv ====
// Purpose: self-checking bench of the acceptance analyzer
// Assumes: dead time shortened to 400 cycles
// Notes:   expected tape words queued by the driver, popped on tapeWrite
`timescale 1ns/1ps
`default_nettype none
module xray_event_acceptance_analyzer_test;
  logic        core_clk, sys_rst, start;
  logic [16:0] inp;
  logic        mainInhibit, readoutCmd, scalerReset, tapeWrite, linGateOpen;
  logic        stopGateOut, analyzerBusy, plValid;
  logic [1:0]  plChannel;
  logic [15:0] tapeTracks;
  logic [15:0] q[$];
  int          miscompares, checks_done, seed, n;
  xray_event_acceptance_analyzer #(.BUSY_CYC(400)) i_dut (.core_clk, .sys_rst,
    .krLowThr(inp[0]), .krHighThr(inp[1]), .csLowThr(inp[2]), .csHighThr(inp[3]),
    .fastShaper(inp[4]), .peakDetect(inp[5]), .plThr10(inp[6]), .plThr20(inp[7]),
    .plThr40(inp[8]), .plThr100(inp[9]), .convDrive(inp[10]), .mainInhibit,
    .readoutCmd, .rateReadout(inp[13]), .overloadWindow(inp[14]),
    .overloadReadout(inp[15]), .scalerReset, .tapeTracks, .tapeWrite, .linGateOpen,
    .stopGateOut, .analyzerBusy, .plChannel, .plValid);
  timing_gen_model i_tg (.core_clk, .sys_rst, .start, .mainInhibit, .readoutCmd,
    .scalerReset);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    // a readout that never came leaves its note behind
    miscompares += q.size();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] e);
    q.push_back(e);
    start <= 1'b1;
    @(posedge core_clk) start <= 1'b0;
    repeat (600) @(posedge core_clk);
  endtask
  task automatic ev(input logic [16:0] m, input int c, input logic [15:0] e);
    inp <= inp | m;
    repeat (5) @(posedge core_clk);
    inp <= inp & ~m;
    repeat (60) @(posedge core_clk);
    inp[10] <= 1'b1;
    repeat (c * 50 + 25) @(posedge core_clk);
    inp[10] <= 1'b0;
    repeat (100) @(posedge core_clk);
    rd(e);
  endtask
  always @(posedge core_clk) begin
    if (!sys_rst && tapeWrite === 1'b1) begin
      if (q.size() == 0) chk("tape spare", 16'h0000, tapeTracks);
      else chk("tape word", q.pop_front(), tapeTracks);
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    {sys_rst, start, inp, miscompares, checks_done, seed} = {1'b1, 18'h00000, 64'h0, 32'h320C};
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    n = 1 + ($unsigned($random(seed)) % 15);
    ev(17'h00001, n, 16'(n) | 16'h2000);
    n = 1 + ($unsigned($random(seed)) % 15);
    ev(17'h00004, n, 16'(n) | 16'h8000);
    ev(17'h00003, 3, 16'h0000);
    ev(17'h00005, 3, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      inp[0] <= 1'b1;
      repeat (5) @(posedge core_clk);
      inp[0] <= 1'b0;
      repeat (200) @(posedge core_clk);
    end
    repeat (300) @(posedge core_clk);
    inp[13] <= 1'b1;
    // cesium event inside the rate sequence must not count
    inp[2]  <= 1'b1;
    rd(16'h4041);
    inp[13] <= 1'b0;
    inp[2]  <= 1'b0;
    inp[14] <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      repeat (20) @(posedge core_clk);
      inp[i < 3 ? 3 : 9] <= 1'b1;
      repeat (5) @(posedge core_clk);
      inp[3] <= 1'b0;
      inp[9] <= 1'b0;
    end
    repeat (300) @(posedge core_clk);
    inp[14] <= 1'b0;
    inp[15] <= 1'b1;
    rd(16'h6083);
    inp[15] <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      inp[9:6] <= 4'((1 << (c + 1)) - 1);
      inp[4] <= 1'b1;
      repeat (20) @(posedge core_clk);
      inp[5] <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk("plastic class", 16'(c) | 16'h0100, {7'h00, plValid, 6'h00, plChannel});
      inp[9:4] <= 6'h00;
      repeat (30) @(posedge core_clk);
    end
    // lowest plastic threshold high, so only the coincidence can withhold the class
    inp[6:4] <= 3'h7;
    repeat (8) @(posedge core_clk);
    chk("coincidence", 16'h0001, {14'h0000, plValid, stopGateOut});
    inp[6:4] <= 3'h0;
    repeat (300) @(posedge core_clk);
    report_and_stop;
  end
endmodule // xray_event_acceptance_analyzer_test
`default_nettype wire
